// ### design/wmi_core.sv
// Rung gated word and double word copy and complement unit
`include "wmi_defs.svh"
module wmi_core #(
    parameter int SLOW_WAIT = `WMI_SLOW_WAIT
) (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    // Rung and operation
    input  wire logic                      rung_on,
    input  wire wmi_pkg::wmi_op_t          op,
    // Source selection
    input  wire logic                      src_is_const,
    input  wire logic [`WMI_DWORD_W-1:0]   src_const,
    input  wire logic [`WMI_ADDR_W-1:0]    src_addr,
    input  wire logic [`WMI_ADDR_W-1:0]    src_index,
    // Destination selection
    input  wire logic [`WMI_ADDR_W-1:0]    dst_addr,
    input  wire logic [`WMI_ADDR_W-1:0]    dst_index,
    input  wire logic                      use_index,
    // Readback
    input  wire logic [`WMI_ADDR_W-1:0]    peek_addr,
    // Results
    output logic                           exec_out,
    output logic                           busy,
    output logic [`WMI_DWORD_W-1:0]        peek_data
);
    wmi_rf_if rf ();
    wmi_pkg::wmi_state_t state_r;
    wmi_pkg::wmi_state_t state_nxt;
    // Wait counter wide enough for the slow path count
    localparam int WAIT_W = $clog2(SLOW_WAIT) + 1;
    logic [WAIT_W-1:0]           wait_r;
    logic                        fast;
    logic                        dbl;
    logic                        inv;
    logic [`WMI_DWORD_W-1:0]     src_val;
    logic [`WMI_DWORD_W-1:0]     res;
    logic [`WMI_ADDR_W-1:0]      eff_src;
    logic [`WMI_ADDR_W-1:0]      eff_dst;
    logic                        wr_go;
    logic                        wr_en_r;
    logic                        wr_dbl_r;
    logic [`WMI_ADDR_W-1:0]      wr_addr_r;
    logic [`WMI_DWORD_W-1:0]     wr_data_r;
    logic [`WMI_WORD_W-1:0]      rd_lo;
    logic [`WMI_WORD_W-1:0]      const_lo;

    // Index modified address
    function automatic logic [`WMI_ADDR_W-1:0] eff_addr(
        input logic [`WMI_ADDR_W-1:0] base,
        input logic [`WMI_ADDR_W-1:0] idx,
        input logic                   en
    );
        eff_addr = en ? base + idx : base;
    endfunction : eff_addr

    wmi_regfile u_rf (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .rf      (rf)
    );

    // Decode operation
    assign dbl     = (op == wmi_pkg::WMI_OP_DCOPY) || (op == wmi_pkg::WMI_OP_DCMPL);
    assign inv     = (op == wmi_pkg::WMI_OP_NOT) || (op == wmi_pkg::WMI_OP_DCMPL);
    assign eff_src = eff_addr(src_addr, src_index, use_index);
    assign eff_dst = eff_addr(dst_addr, dst_index, use_index);
    assign fast    = (op == wmi_pkg::WMI_OP_COPY) && !src_is_const && !use_index;
    assign rf.rd_addr = rung_on ? eff_src : peek_addr;
    // Low words, seen only by the checks below
    assign rd_lo      = rf.rd_data[`WMI_WORD_W-1:0];
    assign const_lo   = src_const[`WMI_WORD_W-1:0];

    // Source operand and result
    always_comb begin
        if (src_is_const) begin
            src_val = dbl ? src_const
                          : {{`WMI_WORD_W{src_const[`WMI_WORD_W-1]}},
                             src_const[`WMI_WORD_W-1:0]};
        end else begin
            src_val = dbl ? rf.rd_data
                          : {`WMI_WORD_ZERO, rf.rd_data[`WMI_WORD_W-1:0]};
        end
        res = inv ? ~src_val : src_val;
    end

    // Write happens at end of fast or slow evaluation
    assign wr_go = rung_on && ((state_r == wmi_pkg::WMI_ST_IDLE && fast)
                   || (state_r == wmi_pkg::WMI_ST_WAIT && wait_r == WAIT_W'(SLOW_WAIT - 1)));

    // Sequence state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            wmi_pkg::WMI_ST_IDLE: begin
                if (rung_on) begin
                    state_nxt = fast ? wmi_pkg::WMI_ST_DONE : wmi_pkg::WMI_ST_WAIT;
                end
            end
            wmi_pkg::WMI_ST_WAIT: begin
                if (!rung_on) begin
                    state_nxt = wmi_pkg::WMI_ST_IDLE;
                end else if (wr_go) begin
                    state_nxt = wmi_pkg::WMI_ST_DONE;
                end
            end
            wmi_pkg::WMI_ST_DONE: begin
                state_nxt = wmi_pkg::WMI_ST_IDLE;
            end
            // Not a one-hot code: recover to idle
            default: begin
                state_nxt = wmi_pkg::WMI_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= wmi_pkg::WMI_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Slow path wait count
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_r != wmi_pkg::WMI_ST_WAIT) begin
            wait_r <= '0;
        end else begin
            wait_r <= wait_r + WAIT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_en_r   <= 1'b0;
            wr_dbl_r  <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            wr_en_r   <= wr_go;
            wr_dbl_r  <= dbl;
            wr_addr_r <= eff_dst;
            wr_data_r <= res;
        end
    end
    assign rf.wr_en   = wr_en_r;
    assign rf.wr_dbl  = wr_dbl_r;
    assign rf.wr_addr = wr_addr_r;
    assign rf.wr_data = wr_data_r;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            exec_out <= 1'b0;
            busy     <= 1'b0;
        end else begin
            exec_out <= wr_go;
            busy     <= rung_on && !wr_go;
        end
    end

    // Registered readback
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            peek_data <= '0;
        end else begin
            peek_data <= rf.rd_data;
        end
    end

    // Output follows a write only
    exec_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        exec_out |-> rf.wr_en) else $error("execution output without write");
    // No action when rung off
    rung_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !rung_on |=> !exec_out && !rf.wr_en) else $error("write with rung off");
    // Fast path completes next edge
    fast_path_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (rung_on && fast && state_r == wmi_pkg::WMI_ST_IDLE) |=> exec_out)
        else $error("fast copy late");
    sequence slow_start_s;
        rung_on && !fast && state_r == wmi_pkg::WMI_ST_IDLE;
    endsequence
    // Slow path bounded
    slow_path_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        slow_start_s ##1 rung_on [*2] |=> exec_out) else $error("slow path late");
    // Invert result
    inv_data_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && inv) |=> rf.wr_data == ~$past(src_val)) else $error("invert wrong");
    // Copy result
    copy_data_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && !inv) |=> rf.wr_data == $past(src_val)) else $error("copy wrong");
    // Pair write for doubles
    pair_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && dbl) |=> rf.wr_dbl) else $error("half pair write");
    // Sign extension of short constant
    const_sext_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (src_is_const && !dbl) |-> src_val[`WMI_DWORD_W-1:`WMI_WORD_W]
            == {`WMI_WORD_W{src_const[`WMI_WORD_W-1]}}) else $error("bad sign");

    // Fast start from idle
    sequence fast_go_s;
        rung_on && fast && state_r == wmi_pkg::WMI_ST_IDLE;
    endsequence
    // Commit step: pulse, write strobe and done state together
    sequence commit_s;
        exec_out && rf.wr_en && state_r == wmi_pkg::WMI_ST_DONE;
    endsequence
    // Settle step: back in idle with both strobes low
    sequence settle_s;
        !exec_out && !rf.wr_en && state_r == wmi_pkg::WMI_ST_IDLE;
    endsequence
    // Rung dropped while the slow count runs
    sequence wait_drop_s;
        !rung_on && state_r == wmi_pkg::WMI_ST_WAIT;
    endsequence
    // One commit, then straight back to idle
    commit_seq_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_go |=> commit_s ##1 settle_s)
        else $error("commit sequence broken");
    // Execution output is a one cycle pulse
    exec_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        exec_out |=> !exec_out)
        else $error("execution output held");
    // Dropped rung abandons the wait with no write
    wait_drop_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wait_drop_s |=> settle_s)
        else $error("write after rung drop");
    // Strobes appear only in the done state
    quiet_state_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r != wmi_pkg::WMI_ST_DONE |-> !rf.wr_en && !exec_out)
        else $error("stray write strobe");
    // Rung off clears busy on the next edge
    busy_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !rung_on |=> !busy)
        else $error("busy with rung off");
    // Busy and the execution output never overlap
    busy_excl_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        busy |-> !exec_out)
        else $error("busy during execution");
    // Fast copy skips the wait state
    fast_skip_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fast_go_s |=> commit_s)
        else $error("fast copy waited");
    // Other operations enter the wait state first
    slow_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        slow_start_s |=> state_r == wmi_pkg::WMI_ST_WAIT && !exec_out)
        else $error("slow path skipped wait");
    // Wait count stays inside its span
    wait_bound_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == wmi_pkg::WMI_ST_WAIT |-> wait_r < WAIT_W'(SLOW_WAIT))
        else $error("wait count overrun");
    // Destination address carried with the write
    dst_addr_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_go |=> rf.wr_addr == $past(eff_dst))
        else $error("wrong destination");
    // Pair flag follows the operation length
    pair_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_go |=> rf.wr_dbl == $past(dbl))
        else $error("pair flag wrong");
    // Single register copy keeps the low word
    word_copy_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && !inv && !dbl && !src_is_const) |=> rf.wr_data[`WMI_WORD_W-1:0] == $past(rd_lo))
        else $error("word copy wrong");
    // Single register invert flips the low word
    word_inv_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && inv && !dbl && !src_is_const) |=> rf.wr_data[`WMI_WORD_W-1:0] == ~$past(rd_lo))
        else $error("word invert wrong");
    // Register pair copy keeps both words
    pair_copy_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && !inv && dbl && !src_is_const) |=> rf.wr_data == $past(rf.rd_data))
        else $error("pair copy wrong");
    // Register pair invert flips both words
    pair_inv_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && inv && dbl && !src_is_const) |=> rf.wr_data == ~$past(rf.rd_data))
        else $error("pair invert wrong");
    // Short constant lands in the low word
    short_const_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && !inv && !dbl && src_is_const) |=> rf.wr_data[`WMI_WORD_W-1:0] == $past(const_lo))
        else $error("short constant wrong");
    // Short constant inverted into the low word
    short_inv_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && inv && !dbl && src_is_const) |=> rf.wr_data[`WMI_WORD_W-1:0] == ~$past(const_lo))
        else $error("short constant invert wrong");
    // Long constant lands whole
    long_const_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && !inv && dbl && src_is_const) |=> rf.wr_data == $past(src_const))
        else $error("long constant wrong");
    // Long constant inverted whole
    long_inv_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_go && inv && dbl && src_is_const) |=> rf.wr_data == ~$past(src_const))
        else $error("long constant invert wrong");
endmodule : wmi_core

// ### include/wmi_defs.svh
// Constants for the word move and invert unit
`ifndef WMI_DEFS_SVH
`define WMI_DEFS_SVH
`define WMI_WORD_W      16
`define WMI_DWORD_W     32
`define WMI_ADDR_W      8
`define WMI_REGS        256
`define WMI_WORD_ZERO   16'h0000
`define WMI_OP_W        4
`define WMI_HI_OFS      8'h01
`define WMI_SLOW_WAIT   2
`endif

// ### include/wmi_pkg.sv
// Types for the word move and invert unit
package wmi_pkg;
    // Operation selected by the sequencer
    typedef enum logic [3:0] {
        WMI_OP_COPY    = 4'b0001,
        WMI_OP_DCOPY   = 4'b0010,
        WMI_OP_NOT     = 4'b0100,
        WMI_OP_DCMPL   = 4'b1000
    } wmi_op_t;
    // Execution state
    typedef enum logic [2:0] {
        WMI_ST_IDLE = 3'b001,
        WMI_ST_WAIT = 3'b010,
        WMI_ST_DONE = 3'b100
    } wmi_state_t;
endpackage : wmi_pkg

// ### include/wmi_rf_if.sv
// Read and write port carrier between the datapath and the register file
`include "wmi_defs.svh"
interface wmi_rf_if;
    logic                      wr_en;
    logic                      wr_dbl;
    logic [`WMI_ADDR_W-1:0]    wr_addr;
    logic [`WMI_DWORD_W-1:0]   wr_data;
    logic [`WMI_ADDR_W-1:0]    rd_addr;
    logic [`WMI_DWORD_W-1:0]   rd_data;
    modport master (output wr_en, output wr_dbl, output wr_addr, output wr_data,
                    output rd_addr, input rd_data);
    modport slave  (input wr_en, input wr_dbl, input wr_addr, input wr_data,
                    input rd_addr, output rd_data);
endinterface : wmi_rf_if

// ### design/wmi_regfile.sv
// Word register file with paired double word access
`include "wmi_defs.svh"
module wmi_regfile (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Access port
    wmi_rf_if.slave   rf
);
    logic [`WMI_WORD_W-1:0] mem_r [`WMI_REGS];
    logic [`WMI_ADDR_W-1:0] hi_wr;
    logic [`WMI_ADDR_W-1:0] hi_rd;

    // Upper word sits at the next higher index
    assign hi_wr = rf.wr_addr + `WMI_HI_OFS;
    assign hi_rd = rf.rd_addr + `WMI_HI_OFS;

    // Low word written, and the upper word on the same edge only for a pair write
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int i = 0; i < `WMI_REGS; i++) begin
                mem_r[i] <= `WMI_WORD_ZERO;
            end
        end else if (rf.wr_en) begin
            mem_r[rf.wr_addr] <= rf.wr_data[`WMI_WORD_W-1:0];
            if (rf.wr_dbl) begin
                mem_r[hi_wr] <= rf.wr_data[`WMI_DWORD_W-1:`WMI_WORD_W];
            end
        end
    end

    // Pair read, upper word from higher index
    assign rf.rd_data = {mem_r[hi_rd], mem_r[rf.rd_addr]};
endmodule : wmi_regfile

// ### bench/wmi_seq.sv
// Scan sequencer model driving one rung and its operands
`include "wmi_defs.svh"
module wmi_seq (
    // Clock and result
    input  wire logic                    clk_sys,
    input  wire logic                    exec_out,
    // Rung and operands
    output logic                         rung_on,
    output wmi_pkg::wmi_op_t             op,
    output logic                         src_is_const,
    output logic [`WMI_DWORD_W-1:0]      src_const,
    output logic [`WMI_ADDR_W-1:0]       src_addr,
    output logic [`WMI_ADDR_W-1:0]       src_index,
    output logic [`WMI_ADDR_W-1:0]       dst_addr,
    output logic [`WMI_ADDR_W-1:0]       dst_index,
    output logic                         use_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // Rung off with operands at rest
    initial begin
        {rung_on, src_is_const, use_index} = 3'b000;
        op = wmi_pkg::WMI_OP_COPY;
        {src_const, src_addr, src_index, dst_addr, dst_index} = 64'h0000_0000_0000_0000;
    end
    // Hold the rung until the execution pulse or the hold limit
    task automatic issue(input wmi_pkg::wmi_op_t o, input logic k, input logic [31:0] c,
            input logic [7:0] s, input logic [7:0] si, input logic [7:0] d,
            input logic [7:0] di, input logic ui, input int hold, output int lat);
        op = o;
        {src_is_const, src_const} = {k, c};
        {src_addr, src_index, dst_addr, dst_index, use_index} = {s, si, d, di, ui};
        rung_on = 1'b1;
        lat = 0;
        do begin
            @(posedge clk_sys);
            #1;
            lat++;
        end while (exec_out !== 1'b1 && lat < hold);
        rung_on = 1'b0;
        // Released constant lines do not keep their last value
        src_const = ~src_const;
    endtask : issue
endmodule : wmi_seq

// ### bench/tb_word_move_invert_unit.sv
// Self-checking bench for the word move and invert unit
`include "wmi_defs.svh"
module tb_word_move_invert_unit;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("BAD %s exp %h seen %h", nm, e, a); end end
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic rung_on, src_is_const, use_index, exec_out, busy;
    wmi_pkg::wmi_op_t op;
    wmi_pkg::wmi_op_t ops [4] = '{wmi_pkg::WMI_OP_COPY, wmi_pkg::WMI_OP_DCOPY,
                                  wmi_pkg::WMI_OP_NOT, wmi_pkg::WMI_OP_DCMPL};
    logic [31:0] cst [4] = '{32'hFFFF_8000, 32'h8000_0000, 32'h0000_7FFF, 32'h7FFF_FFFF};
    logic [31:0] src_const, peek_data, pk_exp;
    logic [7:0]  src_addr, src_index, dst_addr, dst_index;
    logic [7:0]  peek_addr = 8'h00;
    logic [15:0] ref_r [256];
    logic [31:0] exp_q [$];
    int miscompares = 0;
    int comparisons = 0;
    int lat;
    event peek_ev;
    // Clock
    always #4 clk_sys = ~clk_sys;
    // Design and sequencer
    wmi_core DUT (.clk_sys, .reset_n, .rung_on, .op, .src_is_const, .src_const, .src_addr,
        .src_index, .dst_addr, .dst_index, .use_index, .peek_addr, .exec_out, .busy, .peek_data);
    wmi_seq seq (.clk_sys, .exec_out, .rung_on, .op, .src_is_const, .src_const, .src_addr,
        .src_index, .dst_addr, .dst_index, .use_index);
    // Compare each readback with the oldest expected value
    always @(peek_ev) begin
        repeat (2) @(posedge clk_sys);
        #1;
        pk_exp = exp_q.pop_front();
        `CHK("peek_data", pk_exp, peek_data)
    end
    // Read back a register pair
    task automatic peek(input logic [7:0] a);
        exp_q.push_back({ref_r[a + 8'h01], ref_r[a]});
        peek_addr = a;
        ->peek_ev;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : peek
    // One operation, reference update and readback
    task automatic run(input wmi_pkg::wmi_op_t o, input logic k, input logic [31:0] c,
            input logic [7:0] s, input logic [7:0] si, input logic [7:0] d,
            input logic [7:0] di, input logic ui, input int hold);
        logic [7:0]  es;
        logic [7:0]  ed;
        logic [31:0] v;
        es = ui ? s + si : s;
        ed = ui ? d + di : d;
        v = k ? c : {ref_r[es + 8'h01], ref_r[es]};
        // One-hot bits 2 and 3 select the inverting operations
        if (o[2] || o[3]) v = ~v;
        seq.issue(o, k, c, s, si, d, di, ui, hold, lat);
        if (hold > 1) begin
            `CHK("exec_out", 1'b1, exec_out)
            `CHK("done_busy", 1'b0, busy)
            ref_r[ed] = v[15:0];
            if (o[1] || o[3]) ref_r[ed + 8'h01] = v[31:16];
        end else begin
            `CHK("abort_exec", 1'b0, exec_out)
            `CHK("abort_busy", 1'b1, busy)
        end
        peek(ed);
    endtask : run
    // Verdict and end of run
    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // Watchdog
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hc443ec4d));
        foreach (ref_r[i]) ref_r[i] = 16'h0000;
        repeat (12) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        peek(8'h10);
        // Boundary constants for each operation
        for (int i = 0; i < 4; i++) begin
            run(ops[i], 1'b1, cst[i], 8'h00, 8'h00, 8'(8'h20 + 4 * i), 8'h00, 1'b0, 20);
        end
        // Random operands, indexed or not
        for (int i = 0; i < 24; i++) begin
            run(ops[i % 4], 1'($urandom % 2), $urandom, 8'($urandom % 200), 8'($urandom % 8),
                8'($urandom % 200), 8'($urandom % 8), 1'($urandom % 2), 20);
        end
        // Plain register word copy takes the short path, indexed word copy the slow one
        run(wmi_pkg::WMI_OP_COPY, 1'b0, 32'h0000_0000, 8'h20, 8'h00, 8'h40, 8'h00, 1'b0, 20);
        `CHK("fast_lat", 1, lat)
        run(wmi_pkg::WMI_OP_COPY, 1'b0, 32'h0000_0000, 8'h20, 8'h01, 8'h40, 8'h02, 1'b1, 20);
        `CHK("slow_lat", `WMI_SLOW_WAIT + 1, lat)
        // Rung off keeps the output low
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            #1;
            `CHK("idle_exec", 1'b0, exec_out)
            `CHK("idle_busy", 1'b0, busy)
        end
        // Rung dropped mid-wait writes nothing
        run(wmi_pkg::WMI_OP_DCMPL, 1'b1, 32'h1357_9BDF, 8'h00, 8'h00, 8'h24, 8'h00, 1'b0, 1);
        print_verdict();
    end
endmodule : tb_word_move_invert_unit
